// ===== rtl/tsif_pkg.sv
// Package with the register map, field layout and reset values of the trap status and flag block.
package tsif_pkg;

    // ------------------------------------------------------------------
    // Register bus geometry
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned EVT_W  = 8;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL_ONE   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FLAG_FOUR  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_FLAG_FIVE  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 8'h10;

    // ------------------------------------------------------------------
    // Field positions in interrupt_control_one
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_NEST_BIT  = 15;
    localparam int unsigned CTRL_ARITH_BIT = 4;
    localparam int unsigned CTRL_ADDR_BIT  = 3;
    localparam int unsigned CTRL_STACK_BIT = 2;
    localparam int unsigned CTRL_OSC_BIT   = 1;

    // ------------------------------------------------------------------
    // Field positions in the two flag status registers
    // ------------------------------------------------------------------
    localparam int unsigned FOUR_VOLT_BIT  = 8;
    localparam int unsigned FOUR_SER2_BIT  = 2;
    localparam int unsigned FOUR_SER1_BIT  = 1;
    localparam int unsigned FIVE_WAKE_BIT  = 0;

    // ------------------------------------------------------------------
    // Implemented-bit masks; every other bit reads as zero
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] CTRL_IMPL_MASK = 16'h801e;
    localparam logic [DATA_W-1:0] FOUR_IMPL_MASK = 16'h0106;
    localparam logic [DATA_W-1:0] FIVE_IMPL_MASK = 16'h0001;

    // ------------------------------------------------------------------
    // Event positions in the interrupt status and mask registers
    // ------------------------------------------------------------------
    localparam int unsigned EVT_OSC   = 0;
    localparam int unsigned EVT_STACK = 1;
    localparam int unsigned EVT_ADDR  = 2;
    localparam int unsigned EVT_ARITH = 3;
    localparam int unsigned EVT_SER1  = 4;
    localparam int unsigned EVT_SER2  = 5;
    localparam int unsigned EVT_VOLT  = 6;
    localparam int unsigned EVT_WAKE  = 7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] CTRL_RESET  = 16'h0000;
    localparam logic [DATA_W-1:0] FOUR_RESET  = 16'h0000;
    localparam logic [DATA_W-1:0] FIVE_RESET  = 16'h0000;
    localparam logic [EVT_W-1:0]  STAT_RESET  = 8'h00;
    localparam logic [EVT_W-1:0]  MASK_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_IDLE  = 16'h0000;

endpackage

// ===== rtl/tsif_trap_flags.sv
// Trap status, nesting control and interrupt flag registers with a masked interrupt output.
//
// What this block does
// - Bit 15 of interrupt_control_one is nesting_disable: one forbids interrupt nesting, zero allows it.
// - Bit 4 of interrupt_control_one reads one once an arithmetic overflow trap has occurred.
// - Bit 3 of interrupt_control_one reads one once an address error trap has occurred.
// - Bit 2 of interrupt_control_one reads one once a stack error trap has occurred.
// - Bit 1 of interrupt_control_one reads one once an oscillator failure trap has occurred.
// - All unimplemented bits of the three registers read as zero.
// - Each flag reads one after its source has requested an interrupt and stays readable and writable.
// - Bit 0 of interrupt_flag_status_five latches the low-power wake-up request.
`timescale 1ns/1ps
`default_nettype none

module tsif_trap_flags
    import tsif_pkg::*;
(
    input  wire logic              clk,                  // 25 MHz system clock.
    input  wire logic              rstn,                 // Asynchronous reset, active low.
    input  wire logic [ADDR_W-1:0] reg_addr,             // Register byte address.
    input  wire logic [DATA_W-1:0] reg_wdata,            // Register write data.
    input  wire logic              reg_wr,               // Write strobe, one cycle.
    input  wire logic              reg_rd,               // Read strobe, one cycle.
    output logic      [DATA_W-1:0] reg_rdata,            // Read data, valid the cycle after reg_rd.
    input  wire logic              arith_overflow_evt,   // Arithmetic overflow trap event.
    input  wire logic              address_error_evt,    // Address error trap event.
    input  wire logic              stack_error_evt,      // Stack error trap event.
    input  wire logic              osc_failure_evt,      // Oscillator failure trap event.
    input  wire logic              voltage_detect_evt,   // Voltage detect request.
    input  wire logic              serial_one_err_evt,   // First serial port error request.
    input  wire logic              serial_two_err_evt,   // Second serial port error request.
    input  wire logic              low_power_wake_evt,   // Low-power wake-up request.
    output logic                   nesting_disable,      // High while interrupt nesting is forbidden.
    output logic                   irq                   // Level interrupt, high while an unmasked status bit is set.
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] ctrl_reg;
    logic [DATA_W-1:0] ctrl_next;
    logic [DATA_W-1:0] four_reg;
    logic [DATA_W-1:0] four_next;
    logic [DATA_W-1:0] five_reg;
    logic [DATA_W-1:0] five_next;
    logic [EVT_W-1:0]  stat_reg;
    logic [EVT_W-1:0]  stat_next;
    logic [EVT_W-1:0]  mask_reg;
    logic [EVT_W-1:0]  mask_next;
    logic              irq_next;
    logic [DATA_W-1:0] rdata_next;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire logic hit_ctrl = (reg_addr == OFS_CTRL_ONE);
    wire logic hit_four = (reg_addr == OFS_FLAG_FOUR);
    wire logic hit_five = (reg_addr == OFS_FLAG_FIVE);
    wire logic hit_stat = (reg_addr == OFS_IRQ_STATUS);
    wire logic hit_mask = (reg_addr == OFS_IRQ_MASK);

    wire logic wr_ctrl = reg_wr && hit_ctrl;
    wire logic wr_four = reg_wr && hit_four;
    wire logic wr_five = reg_wr && hit_five;
    wire logic wr_stat = reg_wr && hit_stat;
    wire logic wr_mask = reg_wr && hit_mask;

    // ------------------------------------------------------------------
    // Event gathering
    // ------------------------------------------------------------------
    logic [EVT_W-1:0]  evt;
    logic [DATA_W-1:0] ctrl_set;
    logic [DATA_W-1:0] four_set;
    logic [DATA_W-1:0] five_set;

    // Each event lands on its register bit and on its interrupt status bit.
    always_comb begin
        evt                  = '0;
        evt[EVT_OSC]         = osc_failure_evt;
        evt[EVT_STACK]       = stack_error_evt;
        evt[EVT_ADDR]        = address_error_evt;
        evt[EVT_ARITH]       = arith_overflow_evt;
        evt[EVT_SER1]        = serial_one_err_evt;
        evt[EVT_SER2]        = serial_two_err_evt;
        evt[EVT_VOLT]        = voltage_detect_evt;
        evt[EVT_WAKE]        = low_power_wake_evt;
        ctrl_set                 = '0;
        ctrl_set[CTRL_ARITH_BIT] = arith_overflow_evt;
        ctrl_set[CTRL_ADDR_BIT]  = address_error_evt;
        ctrl_set[CTRL_STACK_BIT] = stack_error_evt;
        ctrl_set[CTRL_OSC_BIT]   = osc_failure_evt;
        four_set                 = '0;
        four_set[FOUR_VOLT_BIT]  = voltage_detect_evt;
        four_set[FOUR_SER2_BIT]  = serial_two_err_evt;
        four_set[FOUR_SER1_BIT]  = serial_one_err_evt;
        five_set                 = '0;
        five_set[FIVE_WAKE_BIT]  = low_power_wake_evt;
    end

    // ------------------------------------------------------------------
    // Next values of the software-visible registers
    // ------------------------------------------------------------------
    // A write replaces the implemented bits; an event in the same cycle still sets its bit.
    assign ctrl_next = ((wr_ctrl ? reg_wdata : ctrl_reg) | ctrl_set) & CTRL_IMPL_MASK;
    assign four_next = ((wr_four ? reg_wdata : four_reg) | four_set) & FOUR_IMPL_MASK;
    assign five_next = ((wr_five ? reg_wdata : five_reg) | five_set) & FIVE_IMPL_MASK;

    // Status bits clear by writing one; a new event wins over the clear.
    assign stat_next = (stat_reg & ~(wr_stat ? reg_wdata[EVT_W-1:0] : STAT_RESET)) | evt;
    assign mask_next = wr_mask ? reg_wdata[EVT_W-1:0] : mask_reg;

    // The interrupt follows the registers as they will stand after this edge.
    assign irq_next = |(stat_next & mask_next);

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    // Unmapped addresses and idle cycles return zero.
    assign rdata_next = !reg_rd  ? RDATA_IDLE :
                        hit_ctrl ? ctrl_reg :
                        hit_four ? four_reg :
                        hit_five ? five_reg :
                        hit_stat ? {{(DATA_W-EVT_W){1'b0}}, stat_reg} :
                        hit_mask ? {{(DATA_W-EVT_W){1'b0}}, mask_reg} :
                                   RDATA_IDLE;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Flag and trap registers clear at reset.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= CTRL_RESET;
            four_reg <= FOUR_RESET;
            five_reg <= FIVE_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            four_reg <= four_next;
            five_reg <= five_next;
        end
    end

    // Interrupt status, mask, read data and interrupt output.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stat_reg  <= STAT_RESET;
            mask_reg  <= MASK_RESET;
            reg_rdata <= RDATA_IDLE;
            irq       <= 1'b0;
        end else begin
            stat_reg  <= stat_next;
            mask_reg  <= mask_next;
            reg_rdata <= rdata_next;
            irq       <= irq_next;
        end
    end

    // The nesting control is the stored bit itself, straight from its flip-flop.
    assign nesting_disable = ctrl_reg[CTRL_NEST_BIT];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // A write to the control register sets the nesting output, which holds until the next write there.
    nest_write_a: assert property (
        wr_ctrl |=> (nesting_disable == $past(reg_wdata[CTRL_NEST_BIT]))
                    and (!wr_ctrl [*1] |=> nesting_disable == $past(nesting_disable)))
        else $error("nesting disable does not follow the written value");

    // An overflow event shows in a read of the control register strobed two cycles after it.
    arith_trap_a: assert property (
        arith_overflow_evt ##1 !wr_ctrl ##1 (reg_rd && hit_ctrl) |=> reg_rdata[CTRL_ARITH_BIT])
        else $error("overflow trap not visible on read");

    // An address error event sets its trap bit at the next edge.
    addr_trap_a: assert property (
        address_error_evt |=> ctrl_reg[CTRL_ADDR_BIT])
        else $error("address error trap bit not set");

    // A stack error event sets its trap bit even when software writes zero in the same cycle.
    stack_trap_a: assert property (
        (stack_error_evt && wr_ctrl && !reg_wdata[CTRL_STACK_BIT]) |=> ctrl_reg[CTRL_STACK_BIT])
        else $error("stack error trap lost against a clear");

    // An oscillator failure event sets its bit and it stays until a write or reset.
    osc_trap_a: assert property (
        osc_failure_evt ##1 !wr_ctrl [*3] |-> ctrl_reg[CTRL_OSC_BIT])
        else $error("oscillator failure trap did not stay set");

    // Reads of the control and wake-up registers never show unimplemented bits.
    unimpl_zero_a: assert property (
        reg_rd && (hit_ctrl || hit_five) |=> ($past(hit_five) ? (reg_rdata[15:1] == 15'h0000)
                                                              : ((reg_rdata & ~CTRL_IMPL_MASK) == 16'h0000)))
        else $error("unimplemented bit read as one");

    // A read of the fourth flag register returns the flags held at the strobe.
    flag_read_a: assert property (
        reg_rd && hit_four |=> reg_rdata == $past(four_reg))
        else $error("flag register read data wrong");

    // The wake-up request is latched in bit 0 of the fifth flag register.
    wake_flag_a: assert property (
        low_power_wake_evt |=> five_reg[FIVE_WAKE_BIT] ##1 ($past(wr_five) || five_reg[FIVE_WAKE_BIT]))
        else $error("wake-up flag not latched");

    // Voltage and serial error requests land on bits 8, 2 and 1.
    four_map_a: assert property (
        voltage_detect_evt && serial_two_err_evt && serial_one_err_evt
            |=> four_reg[FOUR_VOLT_BIT] && four_reg[FOUR_SER2_BIT] && four_reg[FOUR_SER1_BIT])
        else $error("fourth flag register bits misplaced");

    // Writing zero with no event pending clears the whole flag register.
    flag_clear_a: assert property (
        wr_four && (reg_wdata == 16'h0000) && !voltage_detect_evt && !serial_one_err_evt
            && !serial_two_err_evt |=> four_reg == 16'h0000)
        else $error("software clear of flags failed");

    // An event whose mask bit is open raises the interrupt at the next edge.
    irq_raise_a: assert property (
        (|(evt & mask_reg)) && !wr_mask |=> irq)
        else $error("interrupt output not raised by an unmasked event");

    // With every mask bit closed the interrupt output stays low.
    irq_mask_a: assert property (
        (mask_reg == 8'h00) && !wr_mask |=> !irq)
        else $error("interrupt output high while fully masked");

    // Writing ones to status bits with no event pending clears exactly those bits.
    stat_clear_a: assert property (
        wr_stat && !(|evt) |=> (stat_reg & $past(reg_wdata[EVT_W-1:0])) == 8'h00)
        else $error("status bits not cleared by a write of one");

    // Every event sets its status bit, whatever software writes in the same cycle.
    stat_set_a: assert property (
        (|evt) |=> (stat_reg & $past(evt)) == $past(evt))
        else $error("status bit not set by its event");

    // Trap bits that are set stay set while software leaves the control register alone.
    ctrl_hold_a: assert property (
        !wr_ctrl |=> (ctrl_reg & $past(ctrl_reg)) == $past(ctrl_reg))
        else $error("control register bit dropped without a write");

    // Flags of the fourth register stay set while software leaves it alone.
    four_hold_a: assert property (
        !wr_four |=> (four_reg & $past(four_reg)) == $past(four_reg))
        else $error("fourth flag register bit dropped without a write");

    // The wake-up flag stays set while software leaves the fifth register alone.
    five_hold_a: assert property (
        !wr_five |=> (five_reg & $past(five_reg)) == $past(five_reg))
        else $error("fifth flag register bit dropped without a write");

    // A control write with no trap event stores exactly the implemented bits of the word.
    ctrl_write_a: assert property (
        wr_ctrl && !arith_overflow_evt && !address_error_evt && !stack_error_evt && !osc_failure_evt
            |=> ctrl_reg == ($past(reg_wdata) & CTRL_IMPL_MASK))
        else $error("control register write not stored");

    // A flag write with no request pending stores exactly the implemented bits of the word.
    four_write_a: assert property (
        wr_four && !voltage_detect_evt && !serial_one_err_evt && !serial_two_err_evt
            |=> four_reg == ($past(reg_wdata) & FOUR_IMPL_MASK))
        else $error("fourth flag register write not stored");

    // A wake-up flag write with no request pending stores bit 0 of the word only.
    five_write_a: assert property (
        wr_five && !low_power_wake_evt |=> five_reg == ($past(reg_wdata) & FIVE_IMPL_MASK))
        else $error("fifth flag register write not stored");

    // A voltage detect request sets bit 8 of the fourth flag register.
    volt_flag_a: assert property (
        voltage_detect_evt |=> four_reg[FOUR_VOLT_BIT])
        else $error("voltage detect flag not set");

    // A first serial port error sets bit 1 of the fourth flag register.
    ser_one_flag_a: assert property (
        serial_one_err_evt |=> four_reg[FOUR_SER1_BIT])
        else $error("first serial error flag not set");

    // A second serial port error sets bit 2 of the fourth flag register.
    ser_two_flag_a: assert property (
        serial_two_err_evt |=> four_reg[FOUR_SER2_BIT])
        else $error("second serial error flag not set");

    // An overflow event sets its trap bit at the next edge.
    arith_set_a: assert property (
        arith_overflow_evt |=> ctrl_reg[CTRL_ARITH_BIT])
        else $error("overflow trap bit not set");

    // Read data return to zero in every cycle that does not follow a read strobe.
    rdata_idle_a: assert property (
        !reg_rd |=> reg_rdata == RDATA_IDLE)
        else $error("read data not idle outside a read");

    // Reads of the fourth flag register never show its unimplemented bits.
    four_unimpl_a: assert property (
        reg_rd && hit_four |=> (reg_rdata & ~FOUR_IMPL_MASK) == 16'h0000)
        else $error("unimplemented flag bit read as one");

    // Reads of unmapped addresses return zero.
    unmapped_zero_a: assert property (
        reg_rd && !(hit_ctrl || hit_four || hit_five || hit_stat || hit_mask) |=> reg_rdata == RDATA_IDLE)
        else $error("unmapped address read not zero");

endmodule

`default_nettype wire

// ===== verif/tsif_event_src.sv
// Model of the core and peripheral sources that raise trap and request events.
`timescale 1ns/1ps
`default_nettype none

module tsif_event_src
    import tsif_pkg::*;
(
    input  wire logic             clk,   // System clock.
    input  wire logic             rstn,  // Asynchronous reset, active low.
    input  wire logic [EVT_W-1:0] fire,  // Events to raise, one bit per source.
    output logic      [EVT_W-1:0] evt    // Event lines, in status bit order.
);
    // Each commanded event appears on the next edge and stays high for as long as fire holds it.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            evt <= 8'h00;
        end else begin
            evt <= fire;
        end
    end
endmodule

`default_nettype wire

// ===== verif/test_trap_status_and_irq_flags.sv
// Testbench for the trap status, flag and interrupt block.
`timescale 1ns/1ps
`default_nettype none

module test_trap_status_and_irq_flags
    import tsif_pkg::*;
;
    logic              clk, rstn, reg_wr, reg_rd, nesting_disable, irq;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [EVT_W-1:0]  fire, evt;
    int                n_mismatch, compares;
    // Register and bit that each event source lands in, in status bit order.
    logic [ADDR_W-1:0] ev_addr [8] = '{OFS_CTRL_ONE, OFS_CTRL_ONE, OFS_CTRL_ONE, OFS_CTRL_ONE,
                                       OFS_FLAG_FOUR, OFS_FLAG_FOUR, OFS_FLAG_FOUR, OFS_FLAG_FIVE};
    int unsigned       ev_bit [8] = '{CTRL_OSC_BIT, CTRL_STACK_BIT, CTRL_ADDR_BIT, CTRL_ARITH_BIT,
                                      FOUR_SER1_BIT, FOUR_SER2_BIT, FOUR_VOLT_BIT, FIVE_WAKE_BIT};
    logic [ADDR_W-1:0] reg_tab [3] = '{OFS_CTRL_ONE, OFS_FLAG_FOUR, OFS_FLAG_FIVE};
    logic [DATA_W-1:0] impl_tab [3] = '{CTRL_IMPL_MASK, FOUR_IMPL_MASK, FIVE_IMPL_MASK};

    tsif_trap_flags tsif_trap_flags_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arith_overflow_evt(evt[EVT_ARITH]),
        .address_error_evt(evt[EVT_ADDR]), .stack_error_evt(evt[EVT_STACK]), .osc_failure_evt(evt[EVT_OSC]),
        .voltage_detect_evt(evt[EVT_VOLT]), .serial_one_err_evt(evt[EVT_SER1]),
        .serial_two_err_evt(evt[EVT_SER2]), .low_power_wake_evt(evt[EVT_WAKE]),
        .nesting_disable(nesting_disable), .irq(irq));
    tsif_event_src tsif_event_src_i (.clk(clk), .rstn(rstn), .fire(fire), .evt(evt));

    // Clock at 25 MHz.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Compare, access and event tasks
    // ------------------------------------------------------------------
    task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write; outputs are looked at once the sampling edge has landed.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // One-cycle read; data must stand in the next cycle only and read zero after it.
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk_word(reg_rdata, exp);
        @(posedge clk);
        #1;
        chk_word(reg_rdata, RDATA_IDLE);
    endtask

    // Raises events through the source model and waits until they have been taken.
    task automatic pulse(input logic [EVT_W-1:0] m);
        @(posedge clk);
        fire <= m;
        @(posedge clk);
        fire <= 8'h00;
        @(posedge clk);
        #1;
    endtask

    task automatic end_of_test;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        fire = 8'h00;
        n_mismatch = 0;
        compares = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a <= 20; a += 4) rd(ADDR_W'(a), 16'h0000);
        chk_bit(nesting_disable, 1'b0);
        chk_bit(irq, 1'b0);
        // Every implemented bit takes a one, every other bit reads zero.
        for (int r = 0; r < 3; r++) begin
            wr(reg_tab[r], 16'hffff);
            rd(reg_tab[r], impl_tab[r]);
            wr(reg_tab[r], 16'h0000);
            rd(reg_tab[r], 16'h0000);
        end
        wr(OFS_CTRL_ONE, 16'h8000);
        chk_bit(nesting_disable, 1'b1);
        wr(OFS_CTRL_ONE, 16'h0000);
        chk_bit(nesting_disable, 1'b0);
        wr(8'h14, 16'hffff);
        rd(8'h14, 16'h0000);
        // Each source sets its own bit alone and stays until cleared by software.
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i);
            rd(ev_addr[i], 16'h0001 << ev_bit[i]);
            rd(OFS_IRQ_STATUS, 16'h0001 << i);
            chk_bit(irq, 1'b0);
            wr(ev_addr[i], 16'h0000);
            wr(OFS_IRQ_STATUS, 16'h0001 << i);
            rd(ev_addr[i], 16'h0000);
            rd(OFS_IRQ_STATUS, 16'h0000);
        end
        // Interrupt is raised, masked, unmasked and cleared.
        wr(OFS_IRQ_MASK, 16'h0002);
        pulse(8'h02);
        chk_bit(irq, 1'b1);
        wr(OFS_IRQ_MASK, 16'h0000);
        chk_bit(irq, 1'b0);
        wr(OFS_IRQ_MASK, 16'h0002);
        chk_bit(irq, 1'b1);
        wr(OFS_IRQ_STATUS, 16'h0002);
        chk_bit(irq, 1'b0);
        rd(OFS_CTRL_ONE, 16'h0004);
        // A stack error meets a clearing write in the same cycle, in the control and then the status register.
        fire <= 8'h02;
        wr(OFS_CTRL_ONE, 16'h0000);
        wr(OFS_IRQ_STATUS, 16'h00ff);
        fire <= 8'h00;
        chk_bit(irq, 1'b1);
        rd(OFS_CTRL_ONE, 16'h0004);
        rd(OFS_IRQ_STATUS, 16'h0002);
        // All sources at once, then a reset in mid-run clears everything.
        wr(OFS_IRQ_MASK, 16'h00ff);
        pulse(8'hff);
        chk_bit(irq, 1'b1);
        rd(OFS_CTRL_ONE, 16'h001e);
        rd(OFS_FLAG_FOUR, 16'h0106);
        rd(OFS_FLAG_FIVE, 16'h0001);
        rd(OFS_IRQ_STATUS, 16'h00ff);
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk_bit(irq, 1'b0);
        for (int r = 0; r < 3; r++) rd(reg_tab[r], 16'h0000);
        rd(OFS_IRQ_MASK, 16'h0000);
        end_of_test();
    end

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
endmodule

`default_nettype wire
